// >>> hw/boot_loader.sv
// Function
// - Chip erase wipes all sectors and clears active read or write protection.
// - Chip erase runs with no password check at all.
// - Protect set enables both protections, only after a correct password.
// - Active protections block programmer-mode reads and writes respectively.
// - First byte 86H is timed with the receiver off to find the rate.
// - Unachievable rate halts the loader silently.
// - Load divider, enable receiver, then transmit 86H.
// - Second byte is the command: 10H RAM load, 20H flash sum.
// - Command byte receive error answers x8H with previous upper nibble.
// - Known command is echoed; unknown code answers x1H.
// - RAM load under protection answers x6H and waits again.
// - Twelve password bytes compared in order with stored bytes.
// - Checksum accepted only when covered bytes plus checksum sum to 00H.
// - Password ack priority: x8H, then x1H checksum, x1H mismatch, else x0H.
// - Header: 32-bit address MSB first, then 16-bit count high first.
// - Header checksum errors answer 18H or 11H and abort.
// - Payload stored sequentially; then checksum ack 18H, 11H or 10H.
// - Jump to the load address only after the 10H payload ack.
// - Sum command returns high byte, low byte, then their checksum.
// - Erase command 40H needs echoed enable byte 54H before erasing.
// - Protect set is command code 60H.
`default_nettype none
module boot_loader import boot_pkg::*; #(
  parameter int MEAS_W  = 18,
  parameter int MIN_DIV = 8
) (
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        RXD_IN,
  output logic             TXD_OUT,
  input  wire logic        READ_PROT_IN,
  input  wire logic        WRITE_PROT_IN,
  output logic [3:0]       PWD_IDX_OUT,
  input  wire logic [7:0]  PWD_BYTE_IN,
  output logic             RAM_WE_OUT,
  output logic [31:0]      RAM_ADDR_OUT,
  output logic [7:0]       RAM_DATA_OUT,
  output logic             SUM_REQ_OUT,
  output logic             ERASE_REQ_OUT,
  output logic             ERASE_CLR_PROT_OUT,
  output logic             PROT_REQ_OUT,
  input  wire logic        FLASH_DONE_IN,
  input  wire logic        FLASH_OK_IN,
  input  wire logic [15:0] SUM_VALUE_IN,
  output logic             JUMP_OUT,
  output logic [31:0]      JUMP_ADDR_OUT,
  output logic             PROG_READ_EN_OUT,
  output logic             PROG_WRITE_EN_OUT,
  output logic             LINK_UP_OUT,
  output logic             BOOT_HALT_OUT
);
  localparam int DIV_W = MEAS_W - 1;
  localparam int CNT_W = MEAS_W + 3;

  typedef enum logic [3:0] {
    ST_WAIT_FALL, ST_LOW, ST_SETTLE, ST_HALT, ST_CMD, ST_KEY, ST_PWD,
    ST_HDR, ST_DATA, ST_DCK, ST_FLASH, ST_SEND, ST_JUMP, ST_RUN
  } state_t;

  state_t          state_q, state_d, ret_q, ret_d, rep_ret;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [DIV_W-1:0] baud_divider_ctrl, div_d;
  logic            baud_fraction_ctrl, frac_d;
  logic            receiver_on_bit, rx_on_d;
  logic [7:0]      cmd_q, cmd_d, sum_q, sum_d, last_tx_q, last_tx_d, rep_byte;
  logic            err_q, err_d, pwd_ok_q, pwd_ok_d, rep_go;
  logic [31:0]     addr_q, addr_d, wptr_q, wptr_d, jaddr_d, ram_addr_d;
  logic [15:0]     len_q, len_d;
  logic [2:0][7:0] seq_q, seq_d;
  logic [1:0]      seq_n_q, seq_n_d;
  logic [7:0]      ram_data_d;
  logic            ram_we_d, sum_req_d, erase_req_d, clr_d, prot_req_d, jump_d;
  logic [2:0]      sync_q;
  logic            line_q, line_prev_q;
  logic            rx_valid, rx_err, tx_busy;
  logic [7:0]      rx_byte;

  // Decodes shared by the sequencer
  wire             take     = rx_valid && (state_q inside {ST_CMD, ST_KEY, ST_PWD, ST_HDR, ST_DATA, ST_DCK});
  wire             fell     = line_prev_q & ~line_q;
  wire             meas_max = &cnt_q[MEAS_W-1:0];
  wire [DIV_W-1:0] meas_div = cnt_q[MEAS_W-1:1];
  wire [CNT_W-1:0] settle   = CNT_W'(baud_divider_ctrl) * CNT_W'(SYNC_REST_BITS);
  wire [7:0]       sum_next = add8(sum_q, rx_byte);
  wire             err_all  = err_q | rx_err;
  wire             prot_on  = READ_PROT_IN | WRITE_PROT_IN;
  wire             tx_req   = (state_q == ST_SEND);
  wire             tx_acc   = tx_req & ~tx_busy;
  wire [7:0]       sum_ck   = 8'(ZERO_BYTE - add8(SUM_VALUE_IN[15:8], SUM_VALUE_IN[7:0]));
  wire [7:0]       ack_rx   = {cmd_q[7:4], NIB_RXERR};
  wire [7:0]       ack_bad  = {cmd_q[7:4], NIB_BAD};
  wire [7:0]       ack_ok   = {cmd_q[7:4], NIB_OK};

  assign PWD_IDX_OUT   = cnt_q[3:0];
  assign LINK_UP_OUT   = receiver_on_bit;
  assign BOOT_HALT_OUT = (state_q == ST_HALT);

  // Sequencer: next-state and datapath decisions
  always_comb begin
    state_d = state_q; ret_d = ret_q; cnt_d = cnt_q; div_d = baud_divider_ctrl;
    frac_d = baud_fraction_ctrl; rx_on_d = receiver_on_bit; cmd_d = cmd_q; sum_d = sum_q;
    err_d = err_q; pwd_ok_d = pwd_ok_q; addr_d = addr_q; wptr_d = wptr_q; len_d = len_q;
    seq_d = seq_q; seq_n_d = seq_n_q; last_tx_d = last_tx_q; jaddr_d = JUMP_ADDR_OUT;
    ram_addr_d = RAM_ADDR_OUT; ram_data_d = RAM_DATA_OUT;
    ram_we_d = 1'b0; sum_req_d = 1'b0; erase_req_d = 1'b0; prot_req_d = 1'b0; jump_d = 1'b0;
    clr_d = ERASE_CLR_PROT_OUT;
    rep_go = 1'b0; rep_byte = ZERO_BYTE; rep_ret = ST_CMD;
    case (state_q)
      ST_WAIT_FALL: if (fell) begin
        state_d = ST_LOW;
        cnt_d   = '0;
      end
      ST_LOW: if (line_q) begin
        if (meas_max || meas_div < DIV_W'(MIN_DIV)) begin
          state_d = ST_HALT;
        end else begin
          div_d   = meas_div;
          frac_d  = cnt_q[0];
          cnt_d   = '0;
          state_d = ST_SETTLE;
        end
      end else if (!meas_max) begin
        cnt_d = CNT_W'(cnt_q + 1'b1);
      end
      ST_SETTLE: if (cnt_q >= settle) begin
        rx_on_d  = 1'b1;
        rep_go   = 1'b1;
        rep_byte = SYNC_BYTE;
      end else begin
        cnt_d = CNT_W'(cnt_q + 1'b1);
      end
      ST_CMD: if (take) begin
        rep_go = 1'b1;
        if (rx_err) begin
          rep_byte = ack_rx;
        end else begin
          cmd_d = rx_byte; sum_d = '0; err_d = 1'b0; pwd_ok_d = 1'b1; cnt_d = '0;
          rep_byte = rx_byte;
          case (rx_byte)
            CMD_RAM: if (prot_on) begin
              rep_byte = {rx_byte[7:4], NIB_PROT};
            end else begin
              rep_ret = ST_PWD;
            end
            CMD_PROT:  rep_ret = ST_PWD;
            CMD_ERASE: rep_ret = ST_KEY;
            CMD_SUM:   rep_ret = ST_FLASH;
            CMD_INFO:  rep_ret = ST_CMD;
            default:   rep_byte = {rx_byte[7:4], NIB_BAD};
          endcase
        end
      end
      ST_KEY: if (take) begin
        rep_go = 1'b1;
        if (rx_err) begin
          rep_byte = ack_rx;
        end else if (rx_byte == ERASE_KEY) begin
          rep_byte = rx_byte;
          rep_ret  = ST_FLASH;
        end else begin
          rep_byte = ack_bad;
        end
      end
      ST_PWD: if (take) begin
        sum_d = sum_next; err_d = err_all; cnt_d = CNT_W'(cnt_q + 1'b1);
        if (cnt_q < CNT_W'(PWD_LEN)) begin
          pwd_ok_d = pwd_ok_q & (rx_byte == PWD_BYTE_IN);
        end else begin
          rep_go = 1'b1; cnt_d = '0; sum_d = '0; err_d = 1'b0;
          if (err_all) begin
            rep_byte = ack_rx;
          end else if (sum_next != ZERO_BYTE) begin
            rep_byte = ack_bad;
          end else if (!pwd_ok_q) begin
            rep_byte = ack_bad;
          end else begin
            rep_byte = ack_ok;
            rep_ret  = (cmd_q == CMD_PROT) ? ST_FLASH : ST_HDR;
          end
        end
      end
      ST_HDR: if (take) begin
        sum_d = sum_next; err_d = err_all; cnt_d = CNT_W'(cnt_q + 1'b1);
        if (cnt_q < CNT_W'(ADDR_LEN)) begin
          addr_d = {addr_q[23:0], rx_byte};
        end else if (cnt_q < CNT_W'(HDR_LEN)) begin
          len_d = {len_q[7:0], rx_byte};
        end else begin
          rep_go = 1'b1; sum_d = '0; err_d = 1'b0;
          if (err_all) begin
            rep_byte = ack_rx;
          end else if (sum_next != ZERO_BYTE) begin
            rep_byte = ack_bad;
          end else begin
            rep_byte = ack_ok;
            rep_ret  = (len_q == '0) ? ST_DCK : ST_DATA;
            wptr_d   = addr_q;
            cnt_d    = CNT_W'(len_q);
          end
        end
      end
      ST_DATA: if (take) begin
        ram_we_d = 1'b1; ram_addr_d = wptr_q; ram_data_d = rx_byte;
        wptr_d = wptr_q + 1'b1; sum_d = sum_next; err_d = err_all;
        cnt_d  = CNT_W'(cnt_q - 1'b1);
        if (cnt_q == CNT_W'(1)) begin
          state_d = ST_DCK;
        end
      end
      ST_DCK: if (take) begin
        rep_go = 1'b1;
        if (err_all) begin
          rep_byte = ack_rx;
        end else if (sum_next != ZERO_BYTE) begin
          rep_byte = ack_bad;
        end else begin
          rep_byte = ack_ok;
          rep_ret  = ST_JUMP;
        end
      end
      ST_SEND: if (tx_acc) begin
        seq_d = {ZERO_BYTE, seq_q[2:1]}; seq_n_d = seq_n_q - 1'b1; last_tx_d = seq_q[0];
        if (seq_n_q == 2'd1) begin
          state_d = ret_q;
          if (ret_q == ST_FLASH) begin
            sum_req_d   = (cmd_q == CMD_SUM);
            erase_req_d = (cmd_q == CMD_ERASE);
            clr_d       = prot_on;
            prot_req_d  = (cmd_q == CMD_PROT);
          end
        end
      end
      ST_FLASH: if (FLASH_DONE_IN) begin
        state_d = ST_SEND; ret_d = ST_CMD;
        case (cmd_q)
          CMD_SUM: begin
            seq_d = {sum_ck, SUM_VALUE_IN[7:0], SUM_VALUE_IN[15:8]};
            seq_n_d = 2'd3;
          end
          CMD_ERASE: begin
            seq_d = {ZERO_BYTE, FLASH_OK_IN ? ERASE_OK2 : ERASE_NG2, FLASH_OK_IN ? ERASE_OK1 : ERASE_NG1};
            seq_n_d = 2'd2;
          end
          default: begin
            seq_d = {ZERO_BYTE, FLASH_OK_IN ? PROT_OK2 : PROT_NG2, FLASH_OK_IN ? PROT_OK1 : PROT_NG1};
            seq_n_d = 2'd2;
          end
        endcase
      end
      ST_JUMP: if (!tx_busy) begin
        jump_d = 1'b1; jaddr_d = addr_q; state_d = ST_RUN;
      end
      ST_HALT: state_d = ST_HALT;
      ST_RUN:  state_d = ST_RUN;
      default: state_d = ST_WAIT_FALL;
    endcase
    if (rep_go) begin
      seq_d = {ZERO_BYTE, ZERO_BYTE, rep_byte}; seq_n_d = 2'd1; ret_d = rep_ret; state_d = ST_SEND;
    end
  end

  // Pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sync_q <= '1; line_q <= 1'b1; line_prev_q <= 1'b1;
    end else begin
      sync_q      <= {sync_q[1:0], RXD_IN};
      line_prev_q <= line_q;
      if (sync_q[1] == sync_q[2]) begin
        line_q <= sync_q[2];
      end
    end
  end

  // State registers and registered outputs
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_q <= ST_WAIT_FALL; ret_q <= ST_CMD; cnt_q <= '0; baud_divider_ctrl <= '0;
      baud_fraction_ctrl <= 1'b0; receiver_on_bit <= 1'b0; cmd_q <= '0; sum_q <= '0;
      err_q <= 1'b0; pwd_ok_q <= 1'b0; addr_q <= '0; wptr_q <= '0; len_q <= '0; seq_q <= '0;
      seq_n_q <= '0; last_tx_q <= '0; RAM_WE_OUT <= 1'b0; RAM_ADDR_OUT <= '0; RAM_DATA_OUT <= '0;
      SUM_REQ_OUT <= 1'b0; ERASE_REQ_OUT <= 1'b0; ERASE_CLR_PROT_OUT <= 1'b0; PROT_REQ_OUT <= 1'b0;
      JUMP_OUT <= 1'b0; JUMP_ADDR_OUT <= '0; PROG_READ_EN_OUT <= 1'b0; PROG_WRITE_EN_OUT <= 1'b0;
    end else begin
      state_q <= state_d; ret_q <= ret_d; cnt_q <= cnt_d; baud_divider_ctrl <= div_d;
      baud_fraction_ctrl <= frac_d; receiver_on_bit <= rx_on_d; cmd_q <= cmd_d; sum_q <= sum_d;
      err_q <= err_d; pwd_ok_q <= pwd_ok_d; addr_q <= addr_d; wptr_q <= wptr_d; len_q <= len_d;
      seq_q <= seq_d; seq_n_q <= seq_n_d; last_tx_q <= last_tx_d; RAM_WE_OUT <= ram_we_d;
      RAM_ADDR_OUT <= ram_addr_d; RAM_DATA_OUT <= ram_data_d; SUM_REQ_OUT <= sum_req_d;
      ERASE_REQ_OUT <= erase_req_d; ERASE_CLR_PROT_OUT <= clr_d; PROT_REQ_OUT <= prot_req_d;
      JUMP_OUT <= jump_d; JUMP_ADDR_OUT <= jaddr_d;
      PROG_READ_EN_OUT  <= ~READ_PROT_IN;
      PROG_WRITE_EN_OUT <= ~WRITE_PROT_IN;
    end
  end

  serial_port #(.DIV_W(DIV_W)) u_port (
    .clk_in       (CLK_IN),
    .rst_in       (SYS_RST_IN),
    .line_in      (line_q),
    .rx_on_in     (receiver_on_bit),
    .div_in       (baud_divider_ctrl),
    .frac_in      (baud_fraction_ctrl),
    .take_in      (take),
    .tx_req_in    (tx_req),
    .tx_data_in   (seq_q[0]),
    .rx_valid_out (rx_valid),
    .rx_byte_out  (rx_byte),
    .rx_err_out   (rx_err),
    .tx_busy_out  (tx_busy),
    .txd_out      (TXD_OUT)
  );

  // Checks of the protocol behaviour
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  property p_halt_silent;
    state_q == ST_HALT |=> state_q == ST_HALT && TXD_OUT && !receiver_on_bit;
  endproperty
  a_halt_silent: assert property (p_halt_silent) else $error("halted loader moved or spoke");
  property p_rx_off_measure;
    state_q inside {ST_WAIT_FALL, ST_LOW, ST_SETTLE} |-> !receiver_on_bit;
  endproperty
  a_rx_off_measure: assert property (p_rx_off_measure) else $error("receiver on during sync");
  property p_sync_reply;
    $rose(receiver_on_bit) |-> state_q == ST_SEND && seq_q[0] == SYNC_BYTE && baud_divider_ctrl >= DIV_W'(MIN_DIV);
  endproperty
  a_sync_reply: assert property (p_sync_reply) else $error("sync reply out of order");
  property p_cmd_rxerr;
    state_q == ST_CMD && take && rx_err |=> seq_q[0] == {$past(cmd_q[7:4]), NIB_RXERR} && ret_q == ST_CMD;
  endproperty
  a_cmd_rxerr: assert property (p_cmd_rxerr) else $error("bad receive-error ack");
  property p_sum_echo;
    state_q == ST_CMD && take && !rx_err && rx_byte == CMD_SUM |=> seq_q[0] == CMD_SUM && ret_q == ST_FLASH;
  endproperty
  a_sum_echo: assert property (p_sum_echo) else $error("sum command not echoed");
  property p_ram_prot;
    state_q == ST_CMD && take && !rx_err && rx_byte == CMD_RAM && prot_on
      |=> seq_q[0][3:0] == NIB_PROT && ret_q == ST_CMD;
  endproperty
  a_ram_prot: assert property (p_ram_prot) else $error("protected ram load not refused");
  property p_pwd_ack;
    state_q == ST_PWD && take && cnt_q == CNT_W'(PWD_LEN) && (err_all || !pwd_ok_q)
      |=> seq_q[0][3:0] != NIB_OK && ret_q == ST_CMD;
  endproperty
  a_pwd_ack: assert property (p_pwd_ack) else $error("password error accepted");
  property p_data_ck;
    state_q == ST_DCK && take && !err_all && sum_next != ZERO_BYTE |=> seq_q[0] == ack_bad ##1 ret_q == ST_CMD;
  endproperty
  a_data_ck: assert property (p_data_ck) else $error("payload checksum error missed");
  property p_jump;
    JUMP_OUT |-> JUMP_ADDR_OUT == addr_q && last_tx_q == ack_ok && !tx_busy && $past(state_q) == ST_JUMP;
  endproperty
  a_jump: assert property (p_jump) else $error("jump without normal ack");
  property p_prot_req;
    PROT_REQ_OUT |-> cmd_q == CMD_PROT && pwd_ok_q && !$past(PROT_REQ_OUT);
  endproperty
  a_prot_req: assert property (p_prot_req) else $error("protect set without password");
  property p_erase_req;
    ERASE_REQ_OUT |-> cmd_q == CMD_ERASE && last_tx_q == ERASE_KEY && ERASE_CLR_PROT_OUT == $past(prot_on);
  endproperty
  a_erase_req: assert property (p_erase_req) else $error("erase request malformed");

  c_link_up: cover property ($rose(receiver_on_bit));
  c_jump:    cover property (JUMP_OUT);
  c_sum:     cover property (state_q == ST_FLASH && FLASH_DONE_IN && cmd_q == CMD_SUM);
  c_erase:   cover property (ERASE_REQ_OUT);
endmodule
`default_nettype wire

// >>> hw/boot_pkg.sv
`default_nettype none
package boot_pkg;
  // Link synchronisation and command codes
  localparam logic [7:0] SYNC_BYTE = 8'h86;
  localparam logic [7:0] CMD_RAM   = 8'h10;
  localparam logic [7:0] CMD_SUM   = 8'h20;
  localparam logic [7:0] CMD_INFO  = 8'h30;
  localparam logic [7:0] CMD_ERASE = 8'h40;
  localparam logic [7:0] CMD_PROT  = 8'h60;
  localparam logic [7:0] ERASE_KEY = 8'h54;
  // Low nibbles of acknowledge bytes
  localparam logic [3:0] NIB_OK    = 4'h0;
  localparam logic [3:0] NIB_BAD   = 4'h1;
  localparam logic [3:0] NIB_PROT  = 4'h6;
  localparam logic [3:0] NIB_RXERR = 4'h8;
  // Result bytes of the flash operations
  localparam logic [7:0] ERASE_OK1 = 8'h4F;
  localparam logic [7:0] ERASE_NG1 = 8'h4C;
  localparam logic [7:0] ERASE_OK2 = 8'h5D;
  localparam logic [7:0] ERASE_NG2 = 8'h60;
  localparam logic [7:0] PROT_OK1  = 8'h6F;
  localparam logic [7:0] PROT_NG1  = 8'h6C;
  localparam logic [7:0] PROT_OK2  = 8'h31;
  localparam logic [7:0] PROT_NG2  = 8'h34;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Field lengths in bytes and frame layout in bits
  localparam int ADDR_LEN       = 4;
  localparam int HDR_LEN        = 6;
  localparam int PWD_LEN        = 12;
  localparam int SYNC_REST_BITS = 8;
  localparam int FRAME_BITS     = 10;

  // Unsigned 8-bit sum, overflow dropped
  function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
    return 8'(a + b);
  endfunction
endpackage
`default_nettype wire

// >>> hw/serial_port.sv
`default_nettype none
module serial_port import boot_pkg::*; #(
  parameter int DIV_W = 17
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             line_in,
  input  wire logic             rx_on_in,
  input  wire logic [DIV_W-1:0] div_in,
  input  wire logic             frac_in,
  input  wire logic             take_in,
  input  wire logic             tx_req_in,
  input  wire logic [7:0]       tx_data_in,
  output logic                  rx_valid_out,
  output logic [7:0]            rx_byte_out,
  output logic                  rx_err_out,
  output logic                  tx_busy_out,
  output logic                  txd_out
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_ph_t;

  rx_ph_t           ph_q;
  logic [DIV_W-1:0] rt_q;
  logic [DIV_W-1:0] tt_q;
  logic [2:0]       ri_q;
  logic [3:0]       ti_q;
  logic [7:0]       rsh_q;
  logic [8:0]       tsh_q;
  logic             prev_q;

  // Bit time less one; the fraction stretches every odd bit by a cycle
  function automatic logic [DIV_W-1:0] bit_time(input logic [DIV_W-1:0] d, input logic f, input logic odd);
    return DIV_W'(d + DIV_W'(f & odd) - 1'b1);
  endfunction

  wire rx_fell = prev_q & ~line_in;
  wire rt_end  = (rt_q == '0);
  wire tt_end  = (tt_q == '0);
  wire tx_load = tx_req_in & ~tx_busy_out;

  // Receiver: mid-bit sampling, framing and overrun flagged as receive error
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ph_q         <= RX_IDLE;
      rt_q         <= '0;
      ri_q         <= '0;
      rsh_q        <= '0;
      prev_q       <= 1'b1;
      rx_valid_out <= 1'b0;
      rx_byte_out  <= '0;
      rx_err_out   <= 1'b0;
    end else begin
      prev_q <= line_in;
      if (take_in) begin
        rx_valid_out <= 1'b0;
      end
      case (ph_q)
        RX_IDLE: if (rx_on_in && rx_fell) begin
          ph_q <= RX_START;
          rt_q <= div_in >> 1;
        end
        RX_START: if (rt_end) begin
          ph_q <= line_in ? RX_IDLE : RX_DATA;
          ri_q <= '0;
          rt_q <= bit_time(div_in, frac_in, 1'b1);
        end else begin
          rt_q <= rt_q - 1'b1;
        end
        RX_DATA: if (rt_end) begin
          rsh_q <= {line_in, rsh_q[7:1]};
          ri_q  <= ri_q + 1'b1;
          rt_q  <= bit_time(div_in, frac_in, ~ri_q[0]);
          if (&ri_q) begin
            ph_q <= RX_STOP;
          end
        end else begin
          rt_q <= rt_q - 1'b1;
        end
        RX_STOP: if (rt_end) begin
          rx_byte_out  <= rsh_q;
          rx_err_out   <= ~line_in | (rx_valid_out & ~take_in);
          rx_valid_out <= 1'b1;
          ph_q         <= RX_IDLE;
        end else begin
          rt_q <= rt_q - 1'b1;
        end
        default: ph_q <= RX_IDLE;
      endcase
    end
  end

  // Transmitter: start bit, eight data bits LSB first, one stop bit
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_busy_out <= 1'b0;
      txd_out     <= 1'b1;
      tsh_q       <= '1;
      ti_q        <= '0;
      tt_q        <= '0;
    end else if (tx_load) begin
      tx_busy_out <= 1'b1;
      txd_out     <= 1'b0;
      tsh_q       <= {1'b1, tx_data_in};
      ti_q        <= '0;
      tt_q        <= bit_time(div_in, frac_in, 1'b0);
    end else if (tx_busy_out) begin
      if (!tt_end) begin
        tt_q <= tt_q - 1'b1;
      end else if (ti_q == 4'(FRAME_BITS - 1)) begin
        tx_busy_out <= 1'b0;
        txd_out     <= 1'b1;
      end else begin
        txd_out <= tsh_q[0];
        tsh_q   <= {1'b1, tsh_q[8:1]};
        ti_q    <= ti_q + 1'b1;
        tt_q    <= bit_time(div_in, frac_in, ~ti_q[0]);
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/boot_host.sv
`default_nettype none
module boot_host #(
  parameter int BIT = 16
) (
  input  wire logic       clk_in,
  input  wire logic       txd_in,
  output var  logic       rxd_out,
  output var  logic       got_out,
  output var  logic [7:0] byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Controller frame: start, eight bits LSB first, stop
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in) #1 rxd_out = f[i];
      repeat (bt - 1) @(posedge clk_in);
    end
  endtask
  // Reply bytes sampled at bit middles, flagged at the stop bit
  initial begin
    rxd_out = 1'b1;
    got_out = 1'b0;
    byte_out = 8'h00;
    forever begin
      @(negedge txd_in);
      repeat (BIT + BIT / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        byte_out[i] = txd_in;
        repeat (BIT) @(posedge clk_in);
      end
      got_out = 1'b1;
      @(posedge clk_in);
      got_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/serial_boot_command_protocol_tb.sv
`default_nettype none
module serial_boot_command_protocol_tb;
  import boot_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BT = 16;
  logic        clk = 0, rst = 1, rxd, txd, rprot = 0, wprot = 0, fdone = 0, got, we, jump, jumped = 0;
  logic        sreq, ereq, eclr, preq, prd, pwr, link, halt;
  logic [3:0]  pidx;
  logic [7:0]  wdata, gbyte, e1, stored[16];
  logic [15:0] sval = 16'h0000;
  logic [31:0] waddr, jaddr;
  logic [7:0]  exp_q[$], pwd[$], pw2[$], pay[$];
  int          fail_count = 0, tests_run = 0, nw = 0;
  always #5 clk = ~clk;
  boot_loader dut (.CLK_IN(clk), .SYS_RST_IN(rst), .RXD_IN(rxd), .TXD_OUT(txd), .READ_PROT_IN(rprot),
    .WRITE_PROT_IN(wprot), .PWD_IDX_OUT(pidx), .PWD_BYTE_IN(stored[pidx]), .RAM_WE_OUT(we),
    .RAM_ADDR_OUT(waddr), .RAM_DATA_OUT(wdata), .SUM_REQ_OUT(sreq), .ERASE_REQ_OUT(ereq),
    .ERASE_CLR_PROT_OUT(eclr), .PROT_REQ_OUT(preq), .FLASH_DONE_IN(fdone), .FLASH_OK_IN(1'b1),
    .SUM_VALUE_IN(sval), .JUMP_OUT(jump), .JUMP_ADDR_OUT(jaddr), .PROG_READ_EN_OUT(prd),
    .PROG_WRITE_EN_OUT(pwr), .LINK_UP_OUT(link), .BOOT_HALT_OUT(halt));
  boot_host #(.BIT(BT)) host (.clk_in(clk), .txd_in(txd), .rxd_out(rxd), .got_out(got), .byte_out(gbyte));
  // Comparison and verdict helpers
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic drain();
    for (int n = 0; exp_q.size() != 0; n++) begin
      if (n > 4000) begin
        check("reply wait", 0, 1);
        complete_run();
      end
      @(posedge clk);
    end
  endtask
  task automatic xfer(input logic [7:0] b, input logic [7:0] e);
    exp_q.push_back(e);
    host.send(b, BT);
    drain();
  endtask
  // Sends a field and its checksum, plus an optional checksum fault
  task automatic block(input logic [7:0] q[$], input logic [7:0] bad, input logic [7:0] e);
    logic [7:0] s;
    s = 8'h00;
    exp_q.push_back(e);
    foreach (q[i]) begin
      host.send(q[i], BT);
      s = s + q[i];
    end
    host.send(8'(-s) + bad, BT);
    drain();
  endtask
  // Flash answers one cycle after a request; RAM writes match the payload
  always @(posedge clk) begin
    fdone <= #1 sreq | ereq | preq;
    if (jump) jumped <= 1'b1;
    if (we) begin
      nw++;
      check("ram data", {24'h0, pay[waddr[1:0]]}, {24'h0, wdata});
    end
  end
  // Each reply byte is matched with the oldest expectation
  always @(posedge got) begin
    e1 = exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx;
    check("reply", e1, gbyte);
  end
  // Main sequence
  initial begin
    void'($urandom(32'hd0417067));
    for (int i = 0; i < 12; i++) pwd.push_back(8'($urandom));
    for (int i = 0; i < 3; i++) pay.push_back(8'($urandom));
    foreach (pwd[i]) stored[i] = pwd[i];
    pw2 = pwd;
    pw2[11] = pw2[11] ^ 8'h01;
    sval = 16'($urandom);
    repeat (8) @(posedge clk);
    #1 rst = 0;
    repeat (6) @(posedge clk);
    xfer(SYNC_BYTE, SYNC_BYTE);
    check("link", 1, link);
    xfer(8'h55, 8'h51);
    $display("test sync done");
    @(posedge clk) #1 rprot = 1;
    xfer(CMD_RAM, {CMD_RAM[7:4], NIB_PROT});
    check("programmer read", 0, prd);
    @(posedge clk) #1 rprot = 0;
    wprot = 1;
    xfer(CMD_ERASE, CMD_ERASE);
    check("programmer write", 0, pwr);
    exp_q = {ERASE_KEY, ERASE_OK1, ERASE_OK2};
    host.send(ERASE_KEY, BT);
    drain();
    check("erase clears", 1, eclr);
    @(posedge clk) #1 wprot = 0;
    $display("test erase done");
    exp_q = {CMD_SUM, sval[15:8], sval[7:0], 8'(-(sval[15:8] + sval[7:0]))};
    host.send(CMD_SUM, BT);
    drain();
    xfer(CMD_PROT, CMD_PROT);
    block(pwd, 8'h00, CMD_PROT);
    exp_q = {PROT_OK1, PROT_OK2};
    drain();
    $display("test sum and protect done");
    xfer(CMD_RAM, CMD_RAM);
    block(pwd, 8'h01, 8'h11);
    xfer(CMD_RAM, CMD_RAM);
    block(pw2, 8'h00, 8'h11);
    xfer(CMD_RAM, CMD_RAM);
    block(pwd, 8'h00, 8'h10);
    block({8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h03}, 8'h00, 8'h10);
    block(pay, 8'h00, 8'h10);
    for (int n = 0; n < 300 && !jumped; n++) @(posedge clk);
    check("jump", 1, jumped);
    check("jump address", 32'h0000_1000, jaddr);
    check("write count", 3, nw);
    $display("test ram transfer done");
    @(posedge clk) #1 rst = 1;
    repeat (8) @(posedge clk);
    #1 rst = 0;
    repeat (6) @(posedge clk);
    host.send(SYNC_BYTE, 4);
    repeat (200) @(posedge clk);
    check("halt", 1, halt);
    $display("test halt done");
    complete_run();
  end
endmodule
`default_nettype wire
